// ### verilog/afcd_decoder.sv
/*
  Serial frame command decoder: shifts in 16-bit frames under chip select,
  decodes them at frame end, keeps the channel counter, the scan-2 last
  channel and the alarm threshold programming sequence.
  Assumes sclk, cs_n and data come from the host asynchronously and that
  sclk runs well below core_clk/2; mode and manual channel come from
  mode-control logic on core_clk.
*/
// What this block does
// RQ1 - code 1001 writes scan-2 program register
// RQ2 - bits 9..6 give scan-2 last channel
// RQ3 - scan-2 counter counts zero to last, wraps
// RQ4 - code 0000 keeps current mode unchanged
// RQ5 - hold frame: scan counters keep advancing
// RQ6 - hold frame: manual mode keeps last channel
// RQ7 - code 0000 ignores lower twelve bits
// RQ8 - upper and lower threshold per channel
// RQ9 - groups of four channels, eight registers
// RQ10 - group zero channels 0-3, one 4-7
// RQ11 - nine frames; first only enters programming
// RQ12 - each later frame writes one threshold
// RQ13 - shortened alarm sequences are accepted
// RQ14 - leave programming frame after exit bit
// RQ15 - entry frame is 11 then group number
// RQ16 - bits 15..14 join group to pick channel
// RQ17 - bit 13 picks upper or lower threshold
// RQ18 - bit 12 requests exit, else stay
// RQ19 - sixteen bits MSB first, decode at end
// RQ20 - scan-2 value complete in one frame
`timescale 1ns/1ps
`include "afcd_defines.svh"

module afcd_decoder
  import afcd_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    serial_clock,
  input  wire logic                    chip_select_n,
  input  wire logic                    serial_data_input,
  input  wire afcd_mode_t              mode_sel,
  input  wire logic [`AFCD_CH_W-1:0]   manual_channel,
  input  wire logic [`AFCD_THR_AW-1:0] thr_rd_addr,
  output logic      [`AFCD_THR_W-1:0]  thr_rd_data_r,
  output logic      [`AFCD_CH_W-1:0]   current_channel_r,
  output logic      [`AFCD_CH_W-1:0]   last_channel_r,
  output logic                         alarm_active_r,
  output logic      [1:0]              alarm_group_r,
  output logic                         frame_done_r,
  output logic                         hold_frame_r
);

  logic [`AFCD_SYNC_W-1:0]   pins_s;
  logic                      sclk_s;
  logic                      cs_n_s;
  logic                      sdi_s;
  logic                      sclk_prev_r;
  logic                      cs_n_prev_r;
  logic [4:0]                bit_cnt_r;
  logic [15:0]               shift_r;
  afcd_frame_t               frame_w;
  afcd_state_t               state_r;
  afcd_thr_wr_t              thr_wr;
  logic                      sclk_rise;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      frame_end;
  logic                      in_normal;
  logic                      cmd_hold;
  logic                      cmd_scan2;
  logic                      cmd_alarm;
  logic                      alarm_data;
  logic [`AFCD_CH_W-1:0]     ch_nxt;

  afcd_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({serial_clock, chip_select_n, serial_data_input}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  // edge detection on synchronised copies only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // same level as the synchroniser's reset, so no false rise follows reset
      sclk_prev_r <= 1'b1;
      cs_n_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
      cs_n_prev_r <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign cs_fall   = ~cs_n_s & cs_n_prev_r;
  assign cs_rise   = cs_n_s & ~cs_n_prev_r;

  // shift in MSB first while selected; counter saturates so long frames are rejected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_r <= 5'h00;
    end else if (~cs_n_s && sclk_rise) begin
      shift_r <= {shift_r[14:0], sdi_s}; // see RQ19
      if (bit_cnt_r != `AFCD_CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // only complete frames are decoded; short or long ones are dropped whole
  assign frame_end = cs_rise && (bit_cnt_r == `AFCD_FRAME_BITS); // see RQ19
  assign frame_w   = afcd_frame_t'(shift_r);

  assign in_normal  = (state_r == AFCD_ST_NORMAL);
  assign cmd_hold   = in_normal && (frame_w.cmd == `AFCD_CMD_HOLD); // see RQ4
  assign cmd_scan2  = in_normal && (frame_w.cmd == `AFCD_CMD_SCAN2_PROG); // see RQ1
  assign cmd_alarm  = in_normal && (frame_w.cmd[`AFCD_PFX_HI:`AFCD_PFX_LO] == `AFCD_ALARM_PREFIX); // see RQ15
  assign alarm_data = ~in_normal;

  // alarm sequencer: entry frame stores group only, data frames until exit bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r        <= AFCD_ST_NORMAL;
      alarm_active_r <= 1'b0;
      alarm_group_r  <= `AFCD_GROUP_RESET;
    end else if (frame_end) begin
      case (state_r)
        AFCD_ST_NORMAL: begin
          if (cmd_alarm) begin
            state_r        <= AFCD_ST_ALARM; // see RQ11
            alarm_active_r <= 1'b1;
            alarm_group_r  <= frame_w.cmd[`AFCD_GRP_HI:`AFCD_GRP_LO];
          end
        end
        AFCD_ST_ALARM: begin // see RQ18
          // the exit frame still writes; the following frame decodes normally
          if (frame_w.cmd[`AFCD_EXIT_POS]) begin
            state_r        <= AFCD_ST_NORMAL; // see RQ13 RQ14
            alarm_active_r <= 1'b0;
          end
        end
        default: begin
          state_r        <= AFCD_ST_NORMAL;
          alarm_active_r <= 1'b0;
        end
      endcase
    end
  end

  // address = {group lsb, cc, upper}; groups 2 and 3 have no channels here
  always_comb begin
    thr_wr.we   = frame_end && alarm_data && ~alarm_group_r[1]; // see RQ10 RQ12
    thr_wr.addr = {alarm_group_r[0],
                   frame_w.cmd[`AFCD_CC_HI:`AFCD_CC_LO],
                   frame_w.cmd[`AFCD_UPPER_POS]}; // see RQ16 RQ17
    thr_wr.data = frame_w.lower;
  end

  afcd_thresh_mem u_thr (
    .core_clk  (core_clk),
    .rst       (rst),
    .wr        (thr_wr),
    .rd_addr   (thr_rd_addr),
    .rd_data_r (thr_rd_data_r)
  );

  // one frame is enough; other bits of that frame are ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_channel_r <= `AFCD_LAST_CH_RESET;
    end else if (frame_end && cmd_scan2) begin
      last_channel_r <= frame_w.lower[`AFCD_LAST_HI:`AFCD_LAST_LO]; // see RQ2 RQ20
    end
  end

  // the counter is updated every decoded frame, whatever the command; manual mode loads manual_channel
  always_comb begin
    ch_nxt = current_channel_r;
    case (mode_sel)
      AFCD_MODE_SCAN2: begin
        if (current_channel_r == last_channel_r) begin
          ch_nxt = `AFCD_CH_ZERO; // see RQ3
        end else begin
          ch_nxt = current_channel_r + `AFCD_CH_STEP; // see RQ5
        end
      end
      AFCD_MODE_SCAN1: begin
        if (current_channel_r == `AFCD_SCAN1_LAST) begin
          ch_nxt = `AFCD_CH_ZERO;
        end else begin
          ch_nxt = current_channel_r + `AFCD_CH_STEP; // see RQ5
        end
      end
      default: begin
        ch_nxt = manual_channel; // see RQ6
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      current_channel_r <= `AFCD_CH_ZERO;
    end else if (frame_end) begin
      current_channel_r <= ch_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_done_r <= 1'b0;
      hold_frame_r <= 1'b0;
    end else begin
      frame_done_r <= frame_end;
      hold_frame_r <= frame_end && cmd_hold; // see RQ7
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_normal_frame;
    frame_end && in_normal;
  endsequence

  sequence s_alarm_entry;
    frame_end && cmd_alarm;
  endsequence

  sequence s_alarm_data;
    frame_end && alarm_data;
  endsequence

  scan2_prog_a: // see RQ1
    assert property (frame_end && cmd_scan2 |=> last_channel_r == $past(frame_w.lower[9:6]))
      else $error("scan-2 last channel not stored");

  scan2_hold_a: // see RQ20
    assert property (frame_end && cmd_scan2 ##1 (!frame_end)[*3] |-> $stable(last_channel_r))
      else $error("scan-2 last channel changed without a frame");

  last_ch_keep_a: // see RQ7
    assert property (s_normal_frame and (frame_w.cmd != 4'h9) |=> $stable(last_channel_r))
      else $error("last channel changed by another command");

  scan2_wrap_a: // see RQ3
    assert property (frame_end && mode_sel == AFCD_MODE_SCAN2 && current_channel_r == last_channel_r
                     |=> current_channel_r == 4'h0)
      else $error("scan-2 counter did not wrap to zero");

  scan2_step_a: // see RQ5
    assert property (frame_end && mode_sel == AFCD_MODE_SCAN2 && current_channel_r != last_channel_r
                     |=> current_channel_r == $past(current_channel_r) + 4'h1)
      else $error("scan-2 counter did not advance");

  manual_keep_a: // see RQ6
    assert property (frame_end && mode_sel == AFCD_MODE_MANUAL |=> current_channel_r == $past(manual_channel))
      else $error("manual channel not kept");

  chan_idle_a: // see RQ19
    assert property (!frame_end |=> $stable(current_channel_r))
      else $error("channel moved outside frame end");

  hold_pulse_a: // see RQ4
    assert property (frame_end && in_normal && frame_w.cmd == 4'h0 |=> hold_frame_r ##1 !hold_frame_r)
      else $error("hold frame not flagged for one cycle");

  entry_no_write_a: // see RQ11
    assert property (s_alarm_entry |-> !thr_wr.we ##1 alarm_active_r && alarm_group_r == $past(frame_w.cmd[1:0]))
      else $error("alarm entry frame misbehaved");

  data_write_a: // see RQ12
    assert property (s_alarm_data and (alarm_group_r[1] == 1'b0)
                     |-> thr_wr.we && thr_wr.addr == {alarm_group_r[0], frame_w.cmd[3:1]})
      else $error("alarm data frame did not write its register");

  single_write_a: // see RQ9
    assert property (thr_wr.we |=> !thr_wr.we)
      else $error("more than one threshold write per frame");

  alarm_exit_a: // see RQ14
    assert property (s_alarm_data and frame_w.cmd[0] |=> !alarm_active_r)
      else $error("alarm programming not left after exit bit");

  alarm_stay_a: // see RQ18
    assert property (s_alarm_data and !frame_w.cmd[0] |=> alarm_active_r)
      else $error("alarm programming left without exit bit");

  alarm_short_a: // see RQ13
    assert property (s_alarm_data and frame_w.cmd[0] and (alarm_group_r[1] == 1'b0)
                     |-> thr_wr.we ##1 !alarm_active_r)
      else $error("shortened alarm sequence not written and closed");

  group_high_a: // see RQ10
    assert property (s_alarm_data and (alarm_group_r[1] == 1'b1) |-> !thr_wr.we)
      else $error("write to group without channels");

  no_write_normal_a: // see RQ8
    assert property (in_normal |-> !thr_wr.we)
      else $error("threshold written outside alarm frame");

endmodule // afcd_decoder

// ### shared/afcd_defines.svh
/*
  Constants for the frame command decoder: command codes, field positions,
  reset values and sizes.
  Assumes it is included by bare name, once or more, by package and modules.
*/
`ifndef AFCD_DEFINES_SVH
`define AFCD_DEFINES_SVH

// frame shape
`define AFCD_FRAME_BITS     5'h10
`define AFCD_CNT_MAX        5'h1F
`define AFCD_CMD_W          4
`define AFCD_LOWER_W        12

// command codes in the top four bits
`define AFCD_CMD_HOLD       4'h0
`define AFCD_CMD_SCAN2_PROG 4'h9
`define AFCD_ALARM_PREFIX   2'h3
`define AFCD_PFX_HI         3
`define AFCD_PFX_LO         2

// field positions inside the lower twelve bits
`define AFCD_LAST_HI        9
`define AFCD_LAST_LO        6

// field positions inside the command nibble of alarm data and entry frames
`define AFCD_CC_HI          3
`define AFCD_CC_LO          2
`define AFCD_UPPER_POS      1
`define AFCD_EXIT_POS       0
`define AFCD_GRP_HI         1
`define AFCD_GRP_LO         0

// channel counter
`define AFCD_CH_W           4
`define AFCD_CH_ZERO        4'h0
`define AFCD_CH_STEP        4'h1
`define AFCD_LAST_CH_RESET  4'h7
`define AFCD_SCAN1_LAST     4'h7

// threshold store: 8 channels x upper/lower
`define AFCD_THR_AW         4
`define AFCD_THR_DEPTH      16
`define AFCD_THR_W          12
`define AFCD_THR_RESET      12'h000
`define AFCD_GROUP_RESET    2'h0

// pin synchroniser
`define AFCD_SYNC_W         3

`endif

// ### shared/afcd_pkg.sv
/*
  Types for the frame command decoder: frame carrier, modes, sequencer states.
  Assumes afcd_defines.svh is on the include path.
*/
`include "afcd_defines.svh"

package afcd_pkg;

  typedef struct packed {
    logic [`AFCD_CMD_W-1:0]   cmd;
    logic [`AFCD_LOWER_W-1:0] lower;
  } afcd_frame_t;

  typedef enum logic [1:0] {
    AFCD_MODE_MANUAL,
    AFCD_MODE_SCAN1,
    AFCD_MODE_SCAN2
  } afcd_mode_t;

  typedef enum logic {
    AFCD_ST_NORMAL,
    AFCD_ST_ALARM
  } afcd_state_t;

  typedef struct packed {
    logic                   we;
    logic [`AFCD_THR_AW-1:0] addr;
    logic [`AFCD_THR_W-1:0]  data;
  } afcd_thr_wr_t;

endpackage

// ### verilog/afcd_sync.sv
/*
  Two-flop synchroniser for the serial pins, one chain per bit.
  Assumes inputs are asynchronous to core_clk; the first stage is read only by the second.
*/
`timescale 1ns/1ps
`include "afcd_defines.svh"

module afcd_sync (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic [`AFCD_SYNC_W-1:0] async_in,
  output logic      [`AFCD_SYNC_W-1:0] sync_out
);

  logic [`AFCD_SYNC_W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < `AFCD_SYNC_W; g = g + 1) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_r[g]   <= 1'b1;
          sync_out[g] <= 1'b1;
        end else begin
          meta_r[g]   <= async_in[g];
          sync_out[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule // afcd_sync

// ### verilog/afcd_thresh_mem.sv
/*
  Threshold store: one upper and one lower word per channel, one write port,
  one read port with registered data.
  Assumes write and read come from the core_clk domain.
*/
`timescale 1ns/1ps
`include "afcd_defines.svh"

module afcd_thresh_mem
  import afcd_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire afcd_thr_wr_t            wr,
  input  wire logic [`AFCD_THR_AW-1:0] rd_addr,
  output logic      [`AFCD_THR_W-1:0]  rd_data_r
);

  logic [`AFCD_THR_W-1:0] mem_r [`AFCD_THR_DEPTH]; // see RQ8 RQ9

  // no reset on the array: contents are undefined until programmed
  always_ff @(posedge core_clk) begin
    if (wr.we) begin
      mem_r[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_r <= `AFCD_THR_RESET;
    end else begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

endmodule // afcd_thresh_mem

// ### verification/afcd_host_model.sv
/*
  Host-side serial master model for the frame command decoder.
  Assumes the bench calls send_frame one frame at a time; sclk idles low between frames.
*/
`timescale 1ns/1ps

module afcd_host_model (
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_data_input
);
  initial begin
    serial_clock      = 1'b0;
    chip_select_n     = 1'b1;
    serial_data_input = 1'b0;
  end

  // n rising edges, msb first; data moves only while sclk is low
  task automatic send_frame(input logic [15:0] w, input int n, input int gap_ns);
    chip_select_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_input = w[i];
      #40 serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
    end
    #20 chip_select_n = 1'b1;
    // released line must not keep showing the last bit
    serial_data_input = ~serial_data_input;
    #(gap_ns);
  endtask
endmodule // afcd_host_model

// ### verification/afcd_decoder_tb_top.sv
/*
  Self-checking bench for the frame command decoder: frames from the host model, checks at outputs.
  Assumes afcd_pkg is compiled first and afcd_defines.svh is on the include path.
*/
`timescale 1ns/1ps
`include "afcd_defines.svh"

module afcd_decoder_tb_top;
  import afcd_pkg::*;
  logic                   core_clk;
  logic                   rst;
  logic                   serial_clock;
  logic                   chip_select_n;
  logic                   serial_data_input;
  afcd_mode_t             mode_sel;
  logic [`AFCD_CH_W-1:0]  manual_channel;
  logic [`AFCD_THR_AW-1:0] thr_rd_addr;
  logic [`AFCD_THR_W-1:0] thr_rd_data_r;
  logic [`AFCD_CH_W-1:0]  current_channel_r;
  logic [`AFCD_CH_W-1:0]  last_channel_r;
  logic                   alarm_active_r;
  logic [1:0]             alarm_group_r;
  logic                   frame_done_r;
  logic                   hold_frame_r;
  logic                   got_done;
  logic                   got_hold;
  int                     miscompares;
  int                     check_count;
  int                     cycles;
  logic [15:0]            alarm_w [3] = '{16'hA5A5, 16'hC123, 16'h17FF};
  logic [3:0]             alarm_a [3] = '{4'hD, 4'hE, 4'h8};
  logic [11:0]            alarm_d [3] = '{12'h5A5, 12'h123, 12'h7FF};

  afcd_host_model HOST (
    .serial_clock      (serial_clock),
    .chip_select_n     (chip_select_n),
    .serial_data_input (serial_data_input)
  );

  afcd_decoder DUT (
    .core_clk          (core_clk),
    .rst               (rst),
    .serial_clock      (serial_clock),
    .chip_select_n     (chip_select_n),
    .serial_data_input (serial_data_input),
    .mode_sel          (mode_sel),
    .manual_channel    (manual_channel),
    .thr_rd_addr       (thr_rd_addr),
    .thr_rd_data_r     (thr_rd_data_r),
    .current_channel_r (current_channel_r),
    .last_channel_r    (last_channel_r),
    .alarm_active_r    (alarm_active_r),
    .alarm_group_r     (alarm_group_r),
    .frame_done_r      (frame_done_r),
    .hold_frame_r      (hold_frame_r)
  );

  initial begin
    core_clk = 1'b0;
  end
  always #2 core_clk = ~core_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // about 25 frames of ~340 cycles each, plus reads
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // send one frame, then watch a bounded window for the one-cycle pulses
  task automatic frame(input logic [15:0] w, input int n = 16, input int gap = 0);
    got_done = 1'b0;
    got_hold = 1'b0;
    HOST.send_frame(w, n, gap);
    repeat (12) begin
      @(posedge core_clk);
      #1;
      if (frame_done_r === 1'b1) begin
        got_done = 1'b1;
        got_hold = hold_frame_r;
      end
    end
  endtask

  task automatic rd_thr(input logic [3:0] a, input logic [11:0] exp);
    thr_rd_addr = a;
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(thr_rd_data_r), 16'(exp));
  endtask

  initial begin
    rst            = 1'b1;
    mode_sel       = AFCD_MODE_MANUAL;
    manual_channel = 4'h0;
    thr_rd_addr    = 4'h0;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(current_channel_r), 16'h0000);
    chk(16'(last_channel_r), 16'h0007);
    chk(16'(alarm_active_r), 16'h0000);
    chk(16'(alarm_group_r), 16'h0000);
    // last channel 3 with every don't-care bit set
    frame(16'h9CFF);
    chk(16'(got_done), 16'h0001);
    chk(16'(last_channel_r), 16'h0003);
    frame(16'h9000, 15);
    chk(16'(got_done), 16'h0000);
    chk(16'(last_channel_r), 16'h0003);
    mode_sel = AFCD_MODE_SCAN2;
    // hold frames whose lower bits would otherwise set last to 15
    for (int i = 1; i <= 5; i++) begin
      frame(16'h0FFF);
      chk(16'(got_hold), 16'h0001);
      chk(16'(current_channel_r), 16'(i % 4));
      chk(16'(last_channel_r), 16'h0003);
    end
    mode_sel       = AFCD_MODE_MANUAL;
    manual_channel = 4'h6;
    frame(16'h0000);
    chk(16'(current_channel_r), 16'h0006);
    mode_sel = AFCD_MODE_SCAN1;
    for (int i = 1; i <= 2; i++) begin
      frame(16'h0000);
      chk(16'(current_channel_r), 16'((6 + i) % 8));
    end
    mode_sel = AFCD_MODE_MANUAL;
    // group 1, shortened to three writes; slow host gap
    frame(16'hD000, 16, 400);
    chk(16'(alarm_active_r), 16'h0001);
    chk(16'(alarm_group_r), 16'h0001);
    chk(16'(got_hold), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      frame(alarm_w[i]);
      chk(16'(alarm_active_r), 16'(i != 2));
    end
    frame(16'h9100);
    chk(16'(last_channel_r), 16'h0004);
    chk(16'(alarm_active_r), 16'h0000);
    // group 0, full nine-frame sequence
    frame(16'hC000);
    chk(16'(alarm_group_r), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      frame({i[2:1], i[0], 1'(i == 7), 12'(16'h100 + i)});
      chk(16'(alarm_active_r), 16'(i != 7));
    end
    // group 2 has no channels here: the sequence runs but writes nothing
    frame(16'hE000);
    chk(16'(alarm_group_r), 16'h0002);
    chk(16'(alarm_active_r), 16'h0001);
    frame(16'h1ABC);
    chk(16'(alarm_active_r), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rd_thr(4'(i), 12'(16'h100 + i));
      // address 0 also proves the group 2 exit frame wrote nothing
    end
    for (int i = 0; i < 3; i++) begin
      rd_thr(alarm_a[i], alarm_d[i]);
    end
    report_and_stop();
  end
endmodule // afcd_decoder_tb_top
